// File: rtl/dpr_ctrl.sv
/*
 controller end: issues one user request at a time, keeping precharge, refresh and exit timing.
 assumes the device end of dpr_link_if on the same clock.
*/
`timescale 1ns/1ps
module dpr_ctrl
   import dpr_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   dpr_link_if.ctrl         link,
   input  wire logic        req_valid,
   input  dpr_cmd_type      req_cmd,
   input  wire logic [2:0]  req_bank,
   input  wire logic        req_auto,
   output logic             req_ready,
   input  wire logic        hot,
   input  wire logic        slow_exit,
   input  wire logic        pd_req,
   input  wire logic        sr_req,
   input  wire logic        term_req
);
   import dpr_pkg::*;
   typedef struct packed {
      dpr_cmd_type      cmd;
      logic [2:0]       bank;
      logic             asel;
      logic             gate;
      logic             term;
      logic [CNT_W-1:0] wait_cnt;
      logic [CNT_W-1:0] read_cnt;
      logic [CNT_W-1:0] ref_cnt;
      logic [1:0]       gate_hold;
      logic [7:0]       open;
   } dpr_ctl_state_type;
   dpr_ctl_state_type s_q, s_d;
   logic idle_ok;
   always_comb begin
      s_d = s_q;
      s_d.cmd = CMD_NOP;
      s_d.asel = 1'b0;
      idle_ok = (s_q.wait_cnt == '0) && !link.busy && (s_q.gate_hold == '0);
      if (s_q.wait_cnt != '0) s_d.wait_cnt = s_q.wait_cnt - 1'b1;
      if (s_q.read_cnt != '0) s_d.read_cnt = s_q.read_cnt - 1'b1;
      if (s_q.gate_hold != '0) s_d.gate_hold = s_q.gate_hold - 1'b1;
      if (s_q.ref_cnt != '0) s_d.ref_cnt = s_q.ref_cnt - 1'b1;
      // termination drops a cycle ahead of self-refresh entry, whatever term_req asks
      s_d.term = term_req && !sr_req && s_q.gate && (s_q.read_cnt == '0);
      req_ready = 1'b0;
      if (!s_q.gate) begin
         // leave power-down or self refresh with nop only
         if (idle_ok && !pd_req && !sr_req) begin
            s_d.gate = 1'b1;
            s_d.gate_hold = 2'(GATE_MIN_PULSE_CYC - 1);
            if (link.mode == MODE_SELFREF) begin
               s_d.wait_cnt = CNT_W'(SELFREF_EXIT_NONREAD_CYC);
               s_d.read_cnt = CNT_W'(SELFREF_EXIT_READ_CYC);
            end else begin
               s_d.wait_cnt = CNT_W'(POWERDOWN_EXIT_DELAY_CYC);
               s_d.read_cnt = slow_exit ? CNT_W'(ACTIVE_PD_SLOW_READ_DELAY_CYC)
                                        : CNT_W'(ACTIVE_PD_FAST_READ_DELAY_CYC);
            end
         end
      end else if (idle_ok && (s_q.ref_cnt == '0 || sr_req) && s_q.open != '0) begin
         s_d.cmd = CMD_PRECHARGE;
         s_d.asel = 1'b1;
         s_d.open = '0;
         s_d.wait_cnt = CNT_W'(ALL_BANK_PRECHARGE_CYC);
      end else if (idle_ok && (s_q.ref_cnt == '0
                   || (sr_req && !s_q.term && s_q.read_cnt == '0))) begin
         s_d.cmd = CMD_REFRESH;
         s_d.ref_cnt = hot ? CNT_W'(REFRESH_SPACING_HOT_CYC) : CNT_W'(REFRESH_SPACING_CYC);
         if (sr_req && s_q.ref_cnt != '0) begin
            s_d.gate = 1'b0;
            s_d.gate_hold = 2'(GATE_MIN_PULSE_CYC - 1);
            s_d.ref_cnt = CNT_W'(REFRESH_SPACING_CYC);
         end
      end else if (idle_ok && pd_req) begin
         s_d.gate = 1'b0;
         s_d.gate_hold = 2'(GATE_MIN_PULSE_CYC - 1);
      end else if (idle_ok && req_valid
                   && !(req_cmd == CMD_READ && s_q.read_cnt != '0)) begin
         req_ready = 1'b1;
         s_d.cmd = req_cmd;
         s_d.bank = req_bank;
         s_d.asel = req_auto;
         case (req_cmd)
            CMD_ACTIVATE: s_d.open[req_bank] = 1'b1;
            CMD_PRECHARGE: begin
               if (req_auto) begin
                  s_d.open = '0;
                  s_d.wait_cnt = CNT_W'(ALL_BANK_PRECHARGE_CYC);
               end else begin
                  s_d.open[req_bank] = 1'b0;
                  s_d.wait_cnt = CNT_W'(BANK_PRECHARGE_CYC);
               end
            end
            CMD_READ, CMD_WRITE: begin
               if (!s_q.open[req_bank]) begin
                  s_d.cmd = CMD_ACTIVATE; // open idle bank first
                  s_d.asel = 1'b0;
                  s_d.open[req_bank] = 1'b1;
                  req_ready = 1'b0;
               end else begin
                  if (req_auto) s_d.open[req_bank] = 1'b0;
                  s_d.wait_cnt = (req_cmd == CMD_WRITE)
                     ? CNT_W'(BURST_CYC + WRITE_RECOVERY_CYC) : CNT_W'(BURST_CYC);
                  if (req_cmd == CMD_WRITE) s_d.read_cnt = CNT_W'(BURST_CYC + WRITE_TO_READ_CYC);
               end
            end
            default: ;
         endcase
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         s_q <= '{cmd: CMD_NOP, bank: BANK_RESET, asel: 1'b0, gate: 1'b1, term: 1'b0,
                  wait_cnt: '0, read_cnt: '0, ref_cnt: CNT_W'(REFRESH_SPACING_HOT_CYC),
                  gate_hold: '0, open: '0};
      end else begin
         s_q <= s_d;
      end
   end
   assign link.cmd = s_q.cmd;
   assign link.bank_addr = s_q.bank;
   assign link.all_bank_select_line = s_q.asel;
   assign link.gate = s_q.gate;
   assign link.termination_control = s_q.term;
endmodule

// File: rtl/dpr_pkg.sv
/*
 shared constants and types for the precharge, refresh and power-down command logic.
 assumes one 10 MHz clock shared by both ends and a synchronous active-high reset.
*/
// Notes on behaviour
// - all-bank select line picks one or all banks
// - single closes named bank; all ignores bank address
// - controller activates idle bank before read or write
// - controller waits bank or all-bank precharge time
// - row closes on precharge or auto-precharge access
// - refresh average spacing at most 7.8125us
// - hot case shortens spacing to 3.9us
// - refresh keeps device busy for refresh cycle time
// - close all banks before refresh, all-bank form
// - self refresh: refresh with gate low, idle
// - termination off before self refresh, low after exit
// - only nop until non-read exit delay passes
// - no read until 200 cycles after exit
// - exit delays count from first gate-high edge
// - gate stays high until read exit delay; controller drops it for pd_req without waiting on read_cnt
// - gate high during bursts; write recovery counted
// - power-down: gate low with nop, not busy
// - idle banks give precharge power-down, else active
// - power-down ignores all inputs except gate, termination
// - gate level held three edges; synchronous exit
// - exit delay, fast or slow read delay by bit 12
// - unlocked loop at entry needs reset after exit
package dpr_pkg;
   localparam int NUM_BANKS = 8;
   localparam int CLK_NS = 100;
   localparam int BANK_PRECHARGE_TIME_NS = 15;
   localparam int ALL_BANK_PRECHARGE_TIME_NS = 18;
   localparam int REFRESH_CYCLE_TIME_NS = 328;
   localparam int SELFREF_EXIT_NONREAD_DELAY_NS = 338;
   localparam int REFRESH_SPACING_NS = 7812;
   localparam int REFRESH_SPACING_HOT_NS = 3900;
   localparam int WRITE_RECOVERY_TIME_NS = 15;
   localparam int WRITE_TO_READ_DELAY_NS = 8;
   localparam int MIN_CYC = 1;
   function automatic int up_cyc(input int ns);
      int c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      return (c < MIN_CYC) ? MIN_CYC : c;
   endfunction
   function automatic int dn_cyc(input int ns);
      int c;
      c = ns / CLK_NS;
      return (c < MIN_CYC) ? MIN_CYC : c;
   endfunction
   localparam int BANK_PRECHARGE_CYC = up_cyc(BANK_PRECHARGE_TIME_NS);
   localparam int ALL_BANK_PRECHARGE_CYC = up_cyc(ALL_BANK_PRECHARGE_TIME_NS);
   localparam int REFRESH_CYCLE_CYC = up_cyc(REFRESH_CYCLE_TIME_NS);
   localparam int SELFREF_EXIT_NONREAD_CYC = up_cyc(SELFREF_EXIT_NONREAD_DELAY_NS);
   localparam int SELFREF_EXIT_READ_CYC = 200;
   localparam int REFRESH_SPACING_CYC = dn_cyc(REFRESH_SPACING_NS);
   localparam int REFRESH_SPACING_HOT_CYC = dn_cyc(REFRESH_SPACING_HOT_NS);
   localparam int WRITE_RECOVERY_CYC = up_cyc(WRITE_RECOVERY_TIME_NS);
   localparam int WRITE_TO_READ_MIN_CYC = 2;
   localparam int WRITE_TO_READ_CYC = (up_cyc(WRITE_TO_READ_DELAY_NS) > WRITE_TO_READ_MIN_CYC)
      ? up_cyc(WRITE_TO_READ_DELAY_NS) : WRITE_TO_READ_MIN_CYC;
   localparam int GATE_MIN_PULSE_CYC = 3;
   localparam int POWERDOWN_EXIT_DELAY_CYC = 2;
   localparam int ACTIVE_PD_FAST_READ_DELAY_CYC = 2;
   localparam int ACTIVE_PD_SLOW_READ_DELAY_CYC = 8;
   localparam int BURST_CYC = 4;
   localparam int SLOW_EXIT_BIT = 12;
   localparam int CNT_W = 10;
   localparam logic [2:0] BANK_RESET = 3'h0;
   typedef enum logic [2:0] {
      CMD_NOP, CMD_ACTIVATE, CMD_READ, CMD_WRITE, CMD_PRECHARGE, CMD_REFRESH, CMD_MODE
   } dpr_cmd_type;
   typedef enum logic [2:0] {
      MODE_RUN, MODE_PRE_PD, MODE_ACT_PD, MODE_SELFREF, MODE_SR_EXIT
   } dpr_mode_type;
endpackage

// File: rtl/dpr_link_if.sv
/*
 command link between controller and device end.
 assumes both ends and the testbench share clk.
*/
`timescale 1ns/1ps
interface dpr_link_if;
   import dpr_pkg::*;
   dpr_cmd_type cmd;
   logic [2:0]  bank_addr;
   logic        all_bank_select_line;
   logic        gate;
   logic        termination_control;
   logic        busy;
   logic [7:0]  bank_open;
   dpr_mode_type mode;
   modport device (input cmd, input bank_addr, input all_bank_select_line, input gate,
                   input termination_control, output busy, output bank_open, output mode);
   modport ctrl (output cmd, output bank_addr, output all_bank_select_line, output gate,
                 output termination_control, input busy, input bank_open, input mode);
endinterface

// File: rtl/dpr_device.sv
/*
 device end: bank state, refresh busy time, self refresh and power-down modes.
 assumes the controller keeps the timing it is bound to.
*/
`timescale 1ns/1ps
module dpr_device
   import dpr_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   dpr_link_if.device      link,
   input  wire logic       dll_locked,
   output logic            dll_frozen,
   output logic            term_enable,
   output logic            dll_reset_needed
);
   import dpr_pkg::*;
   typedef struct packed {
      logic [NUM_BANKS-1:0] open;
      dpr_mode_type         mode;
      logic [CNT_W-1:0]     busy_cnt;
      logic                 gate_prev;
      logic                 dll_bad;
      logic                 term;
   } dpr_dev_state_type;
   dpr_dev_state_type s_q, s_d;
   always_comb begin
      s_d = s_q;
      s_d.gate_prev = link.gate;
      if (s_q.busy_cnt != '0) begin
         s_d.busy_cnt = s_q.busy_cnt - 1'b1;
      end
      case (s_q.mode)
         MODE_RUN: begin
            if (s_q.gate_prev && !link.gate) begin
               if (link.cmd == CMD_REFRESH) begin
                  s_d.mode = MODE_SELFREF;
               end else if (link.cmd == CMD_NOP) begin
                  s_d.mode = (s_q.open == '0) ? MODE_PRE_PD : MODE_ACT_PD;
                  s_d.dll_bad = !dll_locked;
               end
            end else if (link.gate) begin
               case (link.cmd)
                  CMD_ACTIVATE: s_d.open[link.bank_addr] = 1'b1;
                  CMD_PRECHARGE: begin
                     if (link.all_bank_select_line) begin
                        s_d.open = '0;
                     end else begin
                        s_d.open[link.bank_addr] = 1'b0;
                     end
                  end
                  CMD_READ, CMD_WRITE: begin
                     if (link.all_bank_select_line) begin
                        s_d.open[link.bank_addr] = 1'b0; // auto-precharge
                     end
                  end
                  CMD_REFRESH: s_d.busy_cnt = CNT_W'(REFRESH_CYCLE_CYC);
                  default: ;
               endcase
            end
         end
         MODE_PRE_PD, MODE_ACT_PD: begin
            // other inputs ignored here
            if (link.gate && link.cmd == CMD_NOP) begin
               s_d.mode = MODE_RUN; // synchronous exit
            end
         end
         MODE_SELFREF: begin
            if (link.gate) begin
               s_d.mode = MODE_SR_EXIT;
               s_d.busy_cnt = CNT_W'(SELFREF_EXIT_READ_CYC);
            end
         end
         MODE_SR_EXIT: begin
            if (s_q.busy_cnt == 1 || s_q.busy_cnt == '0) begin
               s_d.mode = MODE_RUN;
            end
         end
         default: s_d.mode = MODE_RUN;
      endcase
      s_d.term = link.termination_control && (s_q.mode != MODE_SELFREF);
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         s_q <= '{open: '0, mode: MODE_RUN, busy_cnt: '0, gate_prev: 1'b1,
                  dll_bad: 1'b0, term: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end
   assign link.busy = (s_q.busy_cnt != '0);
   assign link.bank_open = s_q.open;
   assign link.mode = s_q.mode;
   assign dll_frozen = (s_q.mode == MODE_PRE_PD);
   assign term_enable = s_q.term;
   assign dll_reset_needed = s_q.dll_bad;
endmodule

// File: bench/dpr_assertions.sv
/*
 checker for the command link between the controller and device ends.
 assumes it sits beside dpr_link_if on the shared clock, rst synchronous high.
*/
`timescale 1ns/1ps
module dpr_assertions (
   input wire logic             clk,
   input wire logic             rst,
   input dpr_pkg::dpr_cmd_type  cmd,
   input wire logic [2:0]       bank_addr,
   input wire logic             all_bank_select_line,
   input wire logic             gate,
   input wire logic             termination_control,
   input wire logic             busy,
   input wire logic [7:0]       bank_open,
   input dpr_pkg::dpr_mode_type mode
);
   import dpr_pkg::*;
   logic [9:0] sr_q;
   logic [7:0] rf_q;
   // saturating, so a long run never wraps back into the read window
   always_ff @(posedge clk) begin
      if (rst) begin
         sr_q <= 10'h3ff;
         rf_q <= 8'h00;
      end else begin
         sr_q <= ($rose(gate) && mode == MODE_SELFREF) ? 10'h001 : sr_q + {9'h000, sr_q != 10'h3ff};
         rf_q <= (cmd == CMD_REFRESH || mode != MODE_RUN) ? 8'h00 : rf_q + 8'h01;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_single_pre_close: assert property (
      cmd == CMD_PRECHARGE && !all_bank_select_line |=>
      bank_open == ($past(bank_open) & ~(8'h01 << $past(bank_addr))))
      else $error("single precharge closed the wrong banks");
   a_all_pre_close: assert property (
      cmd == CMD_PRECHARGE && all_bank_select_line |=> bank_open == 8'h00)
      else $error("all-bank precharge left a bank open");
   a_refresh_idle: assert property (
      cmd == CMD_REFRESH |-> bank_open == 8'h00)
      else $error("refresh with a bank open");
   a_refresh_busy: assert property (
      cmd == CMD_REFRESH && gate |=> busy [*3])
      else $error("busy dropped inside refresh cycle time");
   a_refresh_spacing: assert property (
      rf_q <= 8'h5a)
      else $error("refresh spacing too long");
   a_pd_entry_kind: assert property (
      cmd == CMD_NOP && $fell(gate) && mode == MODE_RUN |=>
      mode == (($past(bank_open) == 8'h00) ? MODE_PRE_PD : MODE_ACT_PD))
      else $error("wrong power-down kind");
   a_sr_entry: assert property (
      cmd == CMD_REFRESH && !gate |-> !termination_control ##1 mode == MODE_SELFREF)
      else $error("self refresh entry wrong");
   a_gate_hold_high: assert property ($rose(gate) |-> gate [*3])
      else $error("gate high too short");
   a_gate_hold_low: assert property ($fell(gate) |-> !gate [*3])
      else $error("gate low too short");
   a_sr_exit_nop: assert property (
      $rose(gate) && mode == MODE_SELFREF |-> (cmd == CMD_NOP) [*4])
      else $error("command inside self refresh exit delay");
   a_sr_read_wait: assert property (cmd == CMD_READ |-> sr_q >= 10'h0c8)
      else $error("read too soon after self refresh");
   a_sr_term_off: assert property (sr_q < 10'h0c8 |-> !termination_control)
      else $error("termination on after self refresh exit");
   a_burst_gate: assert property (
      cmd inside {CMD_READ, CMD_WRITE} |-> gate [*4])
      else $error("gate dropped during burst");
   a_pd_banks_frozen: assert property (
      mode inside {MODE_PRE_PD, MODE_ACT_PD} && !gate |=> $stable(bank_open))
      else $error("bank state moved in power-down");
endmodule

// File: bench/dpr_tb.sv
/*
 self-checking bench: controller and device ends joined by dpr_link_if.
 assumes the rtl package, interface and both ends are compiled first.
*/
`timescale 1ns/1ps
module dpr_tb;
   import dpr_pkg::*;
   logic        clk, rst, req_valid, req_auto, req_ready, hot, slow_exit;
   logic        pd_req, sr_req, term_req, dll_locked, dll_frozen, term_enable, dll_rst;
   dpr_cmd_type req_cmd;
   logic [2:0]  req_bank;
   logic [7:0]  exp_open;
   int          mismatches, cmp_count, gap, max_gap, sr_gap, rd_gap;
   dpr_link_if link();
   dpr_device i_dpr_device (.clk(clk), .rst(rst), .link(link), .dll_locked(dll_locked),
      .dll_frozen(dll_frozen), .term_enable(term_enable), .dll_reset_needed(dll_rst));
   dpr_ctrl i_dpr_ctrl (.clk(clk), .rst(rst), .link(link), .req_valid(req_valid),
      .req_cmd(req_cmd), .req_bank(req_bank), .req_auto(req_auto), .req_ready(req_ready),
      .hot(hot), .slow_exit(slow_exit), .pd_req(pd_req), .sr_req(sr_req), .term_req(term_req));
   dpr_assertions i_dpr_assertions (.clk(clk), .rst(rst), .cmd(link.cmd),
      .bank_addr(link.bank_addr), .all_bank_select_line(link.all_bank_select_line),
      .gate(link.gate), .termination_control(link.termination_control), .busy(link.busy),
      .bank_open(link.bank_open), .mode(link.mode));
   function automatic logic [7:0] nxt(logic [7:0] o, dpr_cmd_type c, logic [2:0] b, logic a);
      case (c)
         CMD_ACTIVATE: return o | (8'h01 << b);
         CMD_PRECHARGE: return a ? 8'h00 : o & ~(8'h01 << b);
         CMD_READ, CMD_WRITE: return a ? o & ~(8'h01 << b) : o;
         default: return o;
      endcase
   endfunction
   // bank state is predicted from the wire, so refresh-driven closes are followed too
   always @(posedge clk) begin
      if (rst) begin
         exp_open <= 8'h00;
         gap <= 0;
         max_gap <= 0;
         rd_gap <= 0;
         sr_gap <= 1000;
      end else begin
         exp_open <= nxt(exp_open, link.cmd, link.bank_addr, link.all_bank_select_line);
         gap <= (link.cmd == CMD_REFRESH || link.mode != MODE_RUN) ? 0 : gap + 1;
         if (gap > max_gap) max_gap <= gap;
         sr_gap <= (link.mode == MODE_SELFREF) ? 0 : sr_gap + 1;
         if (link.cmd == CMD_READ) rd_gap <= sr_gap;
      end
   end
   task automatic check(string name, logic [31:0] exp, logic [31:0] got);
      cmp_count++;
      if (exp !== got) begin
         mismatches++;
         $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
      end
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic step();
      @(posedge clk);
      #1;
   endtask
   task automatic wait_mode(dpr_mode_type m1, dpr_mode_type m2);
      int n;
      n = 0;
      while (link.mode !== m1 && link.mode !== m2 && n < 600) begin
         @(negedge clk);
         n++;
      end
      if (link.mode !== m1 && link.mode !== m2) begin
         check("mode wait", m1, link.mode);
         conclude();
      end
   endtask
   task automatic req(dpr_cmd_type c, logic [2:0] b, logic a);
      int n;
      n = 0;
      step();
      req_valid = 1'b1;
      req_cmd = c;
      req_bank = b;
      req_auto = a;
      @(negedge clk);
      while (req_ready !== 1'b1 && n < 600) begin
         @(negedge clk);
         n++;
      end
      if (req_ready !== 1'b1) begin
         check("ready wait", 1, req_ready);
         conclude();
      end
      step();
      req_valid = 1'b0;
   endtask
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      {rst, dll_locked} = 2'b11;
      {req_valid, req_auto, hot, slow_exit, pd_req, sr_req, term_req} = 7'h00;
      req_cmd = CMD_NOP;
      req_bank = 3'h0;
      {mismatches, cmp_count} = '0;
      void'($urandom(32'haaf9));
      repeat (5) @(posedge clk);
      #1;
      rst = 1'b0;
      @(negedge clk);
      check("reset gate", 1, link.gate);
      check("reset banks", 0, link.bank_open);
      step();
      hot = 1'b1;
      repeat (40) begin
         req(dpr_cmd_type'($urandom_range(4, 1)), 3'($urandom), 1'($urandom));
         repeat (10) @(negedge clk);
         check("bank open", exp_open, link.bank_open);
      end
      check("hot refresh gap", 1, max_gap <= REFRESH_SPACING_HOT_CYC + 10);
      for (int i = 0; i < 2; i++) begin
         req(i ? CMD_PRECHARGE : CMD_ACTIVATE, 3'h5, i[0]);
         dll_locked = i[0];
         slow_exit = 1'($urandom);
         pd_req = 1'b1;
         wait_mode(MODE_ACT_PD, MODE_PRE_PD);
         check("pd kind", (exp_open == 8'h00) ? MODE_PRE_PD : MODE_ACT_PD, link.mode);
         check("dll frozen", link.mode == MODE_PRE_PD, dll_frozen);
         step();
         pd_req = 1'b0;
         wait_mode(MODE_RUN, MODE_RUN);
         if (i == 0) check("dll reset", 1, dll_rst);
      end
      step();
      term_req = 1'b1;
      sr_req = 1'b1;
      wait_mode(MODE_SELFREF, MODE_SELFREF);
      check("sr termination", 0, term_enable);
      check("sr banks", 0, link.bank_open);
      step();
      sr_req = 1'b0;
      req(CMD_READ, 3'h2, 1'b0);
      repeat (4) @(negedge clk);
      check("sr read gap", 1, rd_gap >= SELFREF_EXIT_READ_CYC - 1);
      conclude();
   end
endmodule
